// [hw/pmc_top.sv]
// PMBus command decoder, operation and on/off registers, enable and margin control
`timescale 1ns/1ps
`include "pmc_defines.svh"
module pmc_top (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_drv_out,
   output logic sda_oe_out,
   output logic alert_drv_out,
   output logic alert_oe_out,
   input wire logic [3:0] addr_sel_in,
   input wire logic addr_done_in,
   input wire logic en_pin_in,
   input wire logic vout_ov_in,
   input wire logic iout_oc_in,
   input wire logic vin_uv_in,
   input wire logic over_temp_in,
   input wire logic power_good_in,
   output logic converter_en_out,
   output logic margin_low_out,
   output logic margin_high_out,
   output logic margin_act_fault_out,
   output logic [3:0] margin_level_out,
   output pmc_pkg::pmc_byte_t output_trim_out
);
   import pmc_pkg::*;

   // ****************************************************
   // Helper functions
   // ****************************************************
   // Codes the decoder knows
   function automatic logic is_supported(input pmc_byte_t cmd);
      logic ok;
      ok = 1'b0;
      case (cmd)
         `PMC_CMD_OPERATION, `PMC_CMD_ON_OFF, `PMC_CMD_CLEAR, `PMC_CMD_WP,
         `PMC_CMD_STORE, `PMC_CMD_RESTORE, `PMC_CMD_STAT_BYTE, `PMC_CMD_STAT_WORD: begin
            ok = 1'b1;
         end
         default: begin
            ok = (cmd >= `PMC_CMD_MFR_BASE) && (cmd <= `PMC_CMD_MFR_LAST);
         end
      endcase
      return ok;
   endfunction

   // Byte to send for a given byte index of a read
   function automatic pmc_byte_t tx_pick(input logic [1:0] idx, input pmc_byte_t lo,
                                         input pmc_byte_t hi, input logic word);
      pmc_byte_t v;
      v = `PMC_UNSUP_READ;
      if (idx == 2'h0) begin
         v = lo;
      end else if ((idx == 2'h1) && word) begin
         v = hi;
      end
      return v;
   endfunction

   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   logic [7:0] pins_s;
   logic scl_s, sda_s, en_pin_s, ov_s, oc_s, uv_s, ot_s, pgood_s;

   pmc_sync #(.W(8), .RST_VAL(`PMC_SYNC_RESET)) u_sync (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .d_in({power_good_in, over_temp_in, vin_uv_in, iout_oc_in, vout_ov_in,
             en_pin_in, sda_in, scl_in}),
      .q_out(pins_s)
   );
   assign {pgood_s, ot_s, uv_s, oc_s, ov_s, en_pin_s, sda_s, scl_s} = pins_s;

   // ****************************************************
   // Bus byte engine
   // ****************************************************
   pmc_bus_e state_q, state_d;
   logic scl_prev_q, scl_prev_d, sda_prev_q, sda_prev_d;
   pmc_byte_t shift_q, shift_d, cmd_q, cmd_d, data_q, data_d;
   logic [3:0] bit_q, bit_d;
   logic [1:0] idx_q, idx_d;
   logic rd_q, rd_d, mine_q, mine_d, oe_q, oe_d, txack_q, txack_d;
   logic scl_rise, scl_fall, start_c, stop_c, commit, rd_fault;
   pmc_byte_t rd_lo, stat_lo, stat_hi, tx_now;

   assign scl_rise = scl_s & ~scl_prev_q;
   assign scl_fall = ~scl_s & scl_prev_q;
   assign start_c = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_c = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   // Next state of the byte engine; start and stop win over any bit activity
   always_comb begin
      state_d = state_q;
      scl_prev_d = scl_s;
      sda_prev_d = sda_s;
      shift_d = shift_q;
      cmd_d = cmd_q;
      data_d = data_q;
      bit_d = bit_q;
      idx_d = idx_q;
      rd_d = rd_q;
      mine_d = mine_q;
      oe_d = oe_q;
      txack_d = txack_q;
      commit = 1'b0;
      rd_fault = 1'b0;
      tx_now = tx_pick(idx_q + 2'h1, rd_lo, stat_hi, cmd_q == `PMC_CMD_STAT_WORD);
      if (start_c) begin
         // A repeated start keeps the command pointer
         state_d = PMC_RX;
         bit_d = 4'h0;
         idx_d = 2'h0;
         mine_d = 1'b0;
         oe_d = 1'b0;
      end else if (stop_c) begin
         commit = mine_q & ~rd_q & (idx_q != 2'h0);
         state_d = PMC_IDLE;
         mine_d = 1'b0;
         oe_d = 1'b0;
      end else begin
         case (state_q)
            PMC_RX: begin
               if (scl_rise) begin
                  shift_d = {shift_q[6:0], sda_s};
                  bit_d = bit_q + 4'h1;
               end else if (scl_fall && (bit_q == 4'h8)) begin
                  if (!mine_q) begin
                     if ((shift_q[7:1] == {`PMC_ADDR_PREFIX, addr_sel_in}) && addr_done_in) begin
                        mine_d = 1'b1;
                        rd_d = shift_q[0];
                        oe_d = 1'b1;
                        state_d = PMC_RX_ACK;
                        // reading an unknown code is a comm fault
                        rd_fault = shift_q[0] & ~is_supported(cmd_q);
                     end else begin
                        state_d = PMC_IDLE;
                     end
                  end else begin
                     // every byte is acknowledged, known or not
                     if (idx_q == 2'h0) begin
                        cmd_d = shift_q;
                     end
                     if (idx_q == 2'h1) begin
                        data_d = shift_q;
                     end
                     if (idx_q != 2'h3) begin
                        idx_d = idx_q + 2'h1;
                     end
                     oe_d = 1'b1;
                     state_d = PMC_RX_ACK;
                  end
               end
            end
            PMC_RX_ACK: begin
               if (scl_fall) begin
                  bit_d = 4'h0;
                  if (rd_q) begin
                     // first read byte leaves on this falling edge
                     shift_d = tx_pick(2'h0, rd_lo, stat_hi, cmd_q == `PMC_CMD_STAT_WORD);
                     oe_d = ~shift_d[7];
                     state_d = PMC_TX;
                  end else begin
                     oe_d = 1'b0;
                     state_d = PMC_RX;
                  end
               end
            end
            PMC_TX: begin
               if (scl_fall) begin
                  if (bit_q == 4'h7) begin
                     oe_d = 1'b0;
                     txack_d = 1'b0;
                     state_d = PMC_TX_ACK;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     oe_d = ~shift_q[6];
                     bit_d = bit_q + 4'h1;
                  end
               end
            end
            PMC_TX_ACK: begin
               if (scl_rise) begin
                  txack_d = ~sda_s;
               end else if (scl_fall) begin
                  if (txack_q) begin
                     // Host acked: next byte, a status word sends two
                     if (idx_q != 2'h3) begin
                        idx_d = idx_q + 2'h1;
                     end
                     shift_d = tx_now;
                     oe_d = ~tx_now[7];
                     bit_d = 4'h0;
                     state_d = PMC_TX;
                  end else begin
                     state_d = PMC_IDLE;
                  end
               end
            end
            default: begin
               oe_d = 1'b0;
            end
         endcase
      end
   end

   // Byte engine registers; lines idle high after reset
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         state_q <= PMC_IDLE;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         shift_q <= 8'h00;
         cmd_q <= 8'h00;
         data_q <= 8'h00;
         bit_q <= 4'h0;
         idx_q <= 2'h0;
         rd_q <= 1'b0;
         mine_q <= 1'b0;
         oe_q <= 1'b0;
         txack_q <= 1'b0;
      end else begin
         state_q <= state_d;
         scl_prev_q <= scl_prev_d;
         sda_prev_q <= sda_prev_d;
         shift_q <= shift_d;
         cmd_q <= cmd_d;
         data_q <= data_d;
         bit_q <= bit_d;
         idx_q <= idx_d;
         rd_q <= rd_d;
         mine_q <= mine_d;
         oe_q <= oe_d;
         txack_q <= txack_d;
      end
   end

   // ****************************************************
   // Register file and nonvolatile copy sequence
   // ****************************************************
   pmc_byte_t op_q, op_d, cfg_q, cfg_d, wp_q, wp_d;
   pmc_byte_t cust_q [7];
   pmc_byte_t cust_d [7];
   pmc_seq_e seq_q, seq_d;
   logic [2:0] sidx_q, sidx_d, pidx_q, pidx_d;
   logic pend_q, pend_d, nvm_we, clr_evt, cml_evt;
   pmc_byte_t nvm_wdata, nvm_rdata;

   pmc_nvm #(.W(8), .AW(3)) u_nvm (
      .core_clk_in(core_clk_in),
      .we_in(nvm_we),
      .waddr_in(sidx_q),
      .wdata_in(nvm_wdata),
      .raddr_in(sidx_q),
      .rdata_out(nvm_rdata)
   );

   // Sequence and commit; a commit lands after any restore data in the same cycle
   always_comb begin
      op_d = op_q;
      cfg_d = cfg_q;
      wp_d = wp_q;
      cust_d = cust_q;
      seq_d = seq_q;
      sidx_d = sidx_q;
      pend_d = (seq_q == PMC_SQ_LOAD);
      pidx_d = sidx_q;
      nvm_we = 1'b0;
      clr_evt = 1'b0;
      cml_evt = 1'b0;
      nvm_wdata = (sidx_q == 3'h0) ? cfg_q : cust_q[sidx_q - 3'h1];
      // registered read data lands one cycle after its address
      if (pend_q) begin
         if (pidx_q == 3'h0) begin
            cfg_d = nvm_rdata | `PMC_CFG_FIXED_ONES;
         end else begin
            cust_d[pidx_q - 3'h1] = nvm_rdata;
         end
      end
      case (seq_q)
         PMC_SQ_LOAD, PMC_SQ_SAVE: begin
            // one cell per cycle while saving
            nvm_we = (seq_q == PMC_SQ_SAVE);
            sidx_d = sidx_q + 3'h1;
            if (sidx_q == `PMC_NVM_LAST) begin
               seq_d = PMC_SQ_IDLE;
            end
         end
         default: begin
            sidx_d = 3'h0;
         end
      endcase
      if (commit) begin
         if (!is_supported(cmd_q)) begin
            // ignored, only the fault flag moves
            cml_evt = 1'b1;
         end else if (idx_q == 2'h1) begin
            // bare code; other codes just set the read pointer
            case (cmd_q)
               `PMC_CMD_CLEAR: clr_evt = 1'b1;
               `PMC_CMD_STORE: seq_d = PMC_SQ_SAVE;
               `PMC_CMD_RESTORE: seq_d = PMC_SQ_LOAD;
               default: clr_evt = 1'b0;
            endcase
         end else if (idx_q == 2'h2) begin
            case (cmd_q)
               `PMC_CMD_OPERATION: op_d = data_q;
               `PMC_CMD_ON_OFF: cfg_d = data_q | `PMC_CFG_FIXED_ONES;
               `PMC_CMD_WP: wp_d = data_q;
               `PMC_CMD_CLEAR, `PMC_CMD_STORE, `PMC_CMD_RESTORE: cml_evt = 1'b1;
               `PMC_CMD_STAT_BYTE, `PMC_CMD_STAT_WORD: cml_evt = 1'b0;
               default: cust_d[cmd_q[2:0]] = data_q;
            endcase
         end else begin
            cml_evt = 1'b1;
         end
      end
   end

   // reset starts a restore so saved values return
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         op_q <= `PMC_OP_RESET;
         cfg_q <= `PMC_CFG_RESET;
         wp_q <= `PMC_WP_RESET;
         for (int i = 0; i < 7; i++) begin
            cust_q[i] <= `PMC_MFR_RESET;
         end
         seq_q <= PMC_SQ_LOAD;
         sidx_q <= 3'h0;
         pidx_q <= 3'h0;
         pend_q <= 1'b0;
      end else begin
         op_q <= op_d;
         cfg_q <= cfg_d;
         wp_q <= wp_d;
         cust_q <= cust_d;
         seq_q <= seq_d;
         sidx_q <= sidx_d;
         pidx_q <= pidx_d;
         pend_q <= pend_d;
      end
   end

   // ****************************************************
   // Status, enable and margin outputs
   // ****************************************************
   logic [4:0] flags_q, flags_d;
   logic en_q, en_d, mlow_q, mlow_d, mhigh_q, mhigh_d, mact_q, mact_d, alert_q, alert_d;
   logic [3:0] mlev_q, mlev_d;
   logic cmd_gate, pin_gate, on_bit;

   // gate bits, pin gate set out of reset
   assign cmd_gate = cfg_q[`PMC_CFG_CMD_BIT];
   assign pin_gate = cfg_q[`PMC_CFG_PIN_BIT];
   assign on_bit = op_q[`PMC_OP_ON_BIT];
   // Flags: cml, temp, input uv, output oc, output ov
   assign stat_lo = {1'b0, ~en_q, flags_q[0], flags_q[1], flags_q[2], flags_q[3],
                     flags_q[4], 1'b0};
   assign stat_hi = {flags_q[0], flags_q[1], flags_q[2], 1'b0, ~pgood_s, 3'h0};

   // Read data for the current command pointer
   always_comb begin
      case (cmd_q)
         `PMC_CMD_OPERATION: rd_lo = op_q;
         `PMC_CMD_ON_OFF: rd_lo = cfg_q;
         `PMC_CMD_WP: rd_lo = wp_q;
         `PMC_CMD_STAT_BYTE, `PMC_CMD_STAT_WORD: rd_lo = stat_lo;
         default: begin
            rd_lo = `PMC_UNSUP_READ;
            if (is_supported(cmd_q)) begin
               rd_lo = cust_q[cmd_q[2:0]];
            end
         end
      endcase
   end

   // Enable source selection and margin decode
   always_comb begin
      // set wins over clear so a standing fault keeps alert low
      flags_d = (flags_q & ~{5{clr_evt}}) | {cml_evt | rd_fault, ot_s, uv_s, oc_s, ov_s};
      alert_d = |flags_d;
      case ({cmd_gate, pin_gate})
         2'h1: en_d = en_pin_s;
         2'h2: en_d = on_bit;
         2'h3: en_d = on_bit & en_pin_s;
         default: en_d = addr_done_in;
      endcase
      mlow_d = 1'b0;
      mhigh_d = 1'b0;
      mact_d = 1'b0;
      case (op_q[`PMC_OP_MARGIN_HI:`PMC_OP_MARGIN_LO])
         `PMC_MARGIN_LOW_IGN: mlow_d = 1'b1;
         `PMC_MARGIN_LOW_ACT: begin
            mlow_d = 1'b1;
            mact_d = 1'b1;
         end
         `PMC_MARGIN_HIGH_IGN: mhigh_d = 1'b1;
         `PMC_MARGIN_HIGH_ACT: begin
            mhigh_d = 1'b1;
            mact_d = 1'b1;
         end
         default: mlow_d = 1'b0;
      endcase
      // High level in upper nibble, low level in lower nibble
      mlev_d = 4'h0;
      if (mhigh_d) begin
         mlev_d = cust_q[`PMC_MFR_MARGIN][7:4];
      end else if (mlow_d) begin
         mlev_d = cust_q[`PMC_MFR_MARGIN][3:0];
      end
   end

   // Output flops; the converter stays off through reset
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         flags_q <= 5'h00;
         alert_q <= 1'b0;
         en_q <= 1'b0;
         mlow_q <= 1'b0;
         mhigh_q <= 1'b0;
         mact_q <= 1'b0;
         mlev_q <= 4'h0;
      end else begin
         flags_q <= flags_d;
         alert_q <= alert_d;
         en_q <= en_d;
         mlow_q <= mlow_d;
         mhigh_q <= mhigh_d;
         mact_q <= mact_d;
         mlev_q <= mlev_d;
      end
   end

   // Open-drain pins only ever pull low
   assign sda_drv_out = 1'b0;
   assign alert_drv_out = 1'b0;
   assign sda_oe_out = oe_q;
   assign alert_oe_out = alert_q;
   assign converter_en_out = en_q;
   assign margin_low_out = mlow_q;
   assign margin_high_out = mhigh_q;
   assign margin_act_fault_out = mact_q;
   assign margin_level_out = mlev_q;
   assign output_trim_out = cust_q[`PMC_MFR_TRIM];
endmodule // pmc_top

// [hw/pmc_defines.svh]
// Command codes, bit positions, reset values and fixed patterns of the PMBus control block
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// ****************************************************
// Command codes
// ****************************************************
`define PMC_CMD_OPERATION 8'h01
`define PMC_CMD_ON_OFF 8'h02
`define PMC_CMD_CLEAR 8'h03
`define PMC_CMD_WP 8'h10
`define PMC_CMD_STORE 8'h11
`define PMC_CMD_RESTORE 8'h12
`define PMC_CMD_STAT_BYTE 8'h78
`define PMC_CMD_STAT_WORD 8'h79
`define PMC_CMD_MFR_BASE 8'hD0
`define PMC_CMD_MFR_LAST 8'hD6

// ****************************************************
// Slave address and field positions
// ****************************************************
`define PMC_ADDR_PREFIX 3'h1
`define PMC_OP_ON_BIT 7
`define PMC_OP_MARGIN_HI 5
`define PMC_OP_MARGIN_LO 2
`define PMC_CFG_CMD_BIT 3
`define PMC_CFG_PIN_BIT 2
`define PMC_MARGIN_LOW_IGN 4'h5
`define PMC_MARGIN_LOW_ACT 4'h6
`define PMC_MARGIN_HIGH_IGN 4'h9
`define PMC_MARGIN_HIGH_ACT 4'hA
`define PMC_MFR_TRIM 3'h4
`define PMC_MFR_MARGIN 3'h5

// ****************************************************
// Reset and fixed values
// ****************************************************
`define PMC_CFG_FIXED_ONES 8'h13
`define PMC_CFG_RESET 8'h17
`define PMC_OP_RESET 8'h00
`define PMC_MFR_RESET 8'h00
`define PMC_WP_RESET 8'h00
`define PMC_UNSUP_READ 8'hFF
`define PMC_NVM_LAST 3'h7
`define PMC_SYNC_RESET 8'h03

`endif

// [hw/pmc_pkg.sv]
// Types shared by the PMBus control block
package pmc_pkg;
   typedef logic [7:0] pmc_byte_t;
   typedef enum logic [2:0] {PMC_IDLE, PMC_RX, PMC_RX_ACK, PMC_TX, PMC_TX_ACK} pmc_bus_e;
   typedef enum logic [1:0] {PMC_SQ_IDLE, PMC_SQ_LOAD, PMC_SQ_SAVE} pmc_seq_e;
endpackage

// [hw/pmc_sync.sv]
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pmc_sync #(
   parameter int W = 8,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_q;
   // ****************************************************
   // Only the second stage is visible outside
   // ****************************************************
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         meta_q <= RST_VAL;
         q_out <= RST_VAL;
      end else begin
         meta_q <= d_in;
         q_out <= meta_q;
      end
   end
endmodule // pmc_sync

// [hw/pmc_nvm.sv]
// Small nonvolatile store model with registered read data
`timescale 1ns/1ps
`include "pmc_defines.svh"
module pmc_nvm #(
   parameter int W = 8,
   parameter int AW = 3
) (
   input wire logic core_clk_in,
   input wire logic we_in,
   input wire logic [AW-1:0] waddr_in,
   input wire logic [W-1:0] wdata_in,
   input wire logic [AW-1:0] raddr_in,
   output logic [W-1:0] rdata_out
);
   logic [W-1:0] mem [2**AW];
   // Factory contents; the array is never reset so it survives reset
   initial begin
      for (int i = 0; i < 2**AW; i++) begin
         mem[i] = (i == 0) ? W'(`PMC_CFG_RESET) : W'(`PMC_MFR_RESET);
      end
   end
   // ****************************************************
   // Write port and registered read port
   // ****************************************************
   always_ff @(posedge core_clk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
      rdata_out <= mem[raddr_in];
   end
endmodule // pmc_nvm

// [tb/pmc_host.sv]
// PMBus host model that frames byte writes and reads
`timescale 1ns/1ps
module pmc_host (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_oe_out,
   output logic sda_oe_out
);
   // Both lines released at time zero
   initial begin
      scl_oe_out = 1'b0;
      sda_oe_out = 1'b0;
   end
   task automatic hw(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic start();
      sda_oe_out = 1'b0;
      hw(10);
      scl_oe_out = 1'b0;
      hw(10);
      sda_oe_out = 1'b1;
      hw(10);
      scl_oe_out = 1'b1;
      hw(4);
   endtask
   // SDA moves only while SCL is low, so no false start or stop
   task automatic bitx(input logic b, output logic s);
      sda_oe_out = !b;
      hw(8);
      scl_oe_out = 1'b0;
      hw(5);
      s = sda_in;
      hw(5);
      scl_oe_out = 1'b1;
      hw(2);
   endtask
   // one byte out or in, ninth bit is the acknowledge
   task automatic xbyte(input logic [7:0] o, output logic [7:0] i, output logic k);
      logic r;
      for (int b = 7; b >= 0; b--) bitx(o[b], i[b]);
      bitx(1'b1, r);
      k = !r;
   endtask
   // address, code, n data bytes, optional read with final nack
   task automatic frame(input logic [6:0] a, input logic [7:0] c, input logic [7:0] w,
         input int n, input logic rd, output logic [7:0] q, output logic ok);
      logic k;
      start();
      xbyte({a, 1'b0}, q, ok);
      xbyte(c, q, k);
      ok &= k;
      repeat (n) begin
         xbyte(w, q, k);
         ok &= k;
      end
      if (rd) begin
         start();
         xbyte({a, 1'b1}, q, k);
         ok &= k;
         xbyte(8'hFF, q, k);
      end
      sda_oe_out = 1'b1;
      hw(10);
      scl_oe_out = 1'b0;
      hw(10);
      sda_oe_out = 1'b0;
      hw(20);
   endtask
endmodule // pmc_host

// [tb/pmc_top_sva.sv]
// Port assertions for the PMBus control block
`timescale 1ns/1ps
module pmc_top_sva (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic scl_in,
   input wire logic addr_done_in,
   input wire logic vout_ov_in,
   input wire logic sda_drv_out,
   input wire logic sda_oe_out,
   input wire logic alert_drv_out,
   input wire logic alert_oe_out,
   input wire logic converter_en_out,
   input wire logic margin_low_out,
   input wire logic margin_high_out,
   input wire logic margin_act_fault_out,
   input wire logic [3:0] margin_level_out
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (reset_in);
   sequence s_fault;
      vout_ov_in [*4];
   endsequence
   sequence s_scl_high;
      scl_in [*5];
   endsequence
   a_open_drain: assert property (!sda_drv_out && !alert_drv_out)
      else $error("pin drive value high");
   a_reset_quiet: assert property ($fell(reset_in) |-> !sda_oe_out && !converter_en_out)
      else $error("outputs active after reset");
   a_margin_one: assert property (!(margin_low_out && margin_high_out))
      else $error("both margins active");
   a_margin_off: assert property (!(margin_low_out || margin_high_out) |->
      margin_level_out == 4'h0 && !margin_act_fault_out) else $error("margin off but level");
   a_fault_alert: assert property (s_fault |-> ##[0:3] alert_oe_out)
      else $error("alert missing on fault");
   a_fault_holds: assert property (s_fault ##0 alert_oe_out |=> alert_oe_out)
      else $error("alert dropped on live fault");
   a_no_addr: assert property (!addr_done_in [*8] |-> !sda_oe_out)
      else $error("ack without address detect");
   a_sda_still: assert property (s_scl_high |-> $stable(sda_oe_out))
      else $error("sda changed while scl high");
endmodule // pmc_top_sva
bind pmc_top pmc_top_sva u_sva (.core_clk_in, .reset_in, .scl_in, .addr_done_in, .vout_ov_in,
   .sda_drv_out, .sda_oe_out, .alert_drv_out, .alert_oe_out, .converter_en_out,
   .margin_low_out, .margin_high_out, .margin_act_fault_out, .margin_level_out);

// [tb/tb_pmbus_command_and_enable_control.sv]
// Self-checking bench for the PMBus command and enable control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
$display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_pmbus_command_and_enable_control;
   import pmc_pkg::*;
   logic core_clk_in = 1'b0, reset_in = 1'b1, addr_done_in = 1'b1, en_pin_in = 1'b0;
   logic vout_ov_in = 1'b0, scl_oe, sda_oe, dut_oe, en, mlo, mhi, mact, alert, ok;
   logic [3:0] mlvl;
   logic [6:0] ex;
   pmc_byte_t d, trim;
   int errors = 0, n_compared = 0, cyc = 0;
   // Pulled-up lines: whoever drives low wins
   wire scl = ~scl_oe;
   wire sda = ~(sda_oe | dut_oe);
   always #2 core_clk_in = ~core_clk_in;
   pmc_host host (.clk_in(core_clk_in), .sda_in(sda), .scl_oe_out(scl_oe), .sda_oe_out(sda_oe));
   pmc_top dut (.core_clk_in, .reset_in, .scl_in(scl), .sda_in(sda), .sda_drv_out(),
      .sda_oe_out(dut_oe), .alert_drv_out(), .alert_oe_out(alert), .addr_sel_in(4'h5),
      .addr_done_in, .en_pin_in, .vout_ov_in, .iout_oc_in(vout_ov_in), .vin_uv_in(vout_ov_in),
      .over_temp_in(vout_ov_in), .power_good_in(1'b1), .converter_en_out(en),
      .margin_low_out(mlo), .margin_high_out(mhi), .margin_act_fault_out(mact),
      .margin_level_out(mlvl), .output_trim_out(trim));
   task automatic settle();
      repeat (6) @(negedge core_clk_in);
   endtask
   task automatic wr(input pmc_byte_t c, input pmc_byte_t w, input int n);
      host.frame(7'h15, c, w, n, 1'b0, d, ok);
      `CHK("ack", 1'b1, ok)
      settle();
   endtask
   task automatic rd(input pmc_byte_t c, input pmc_byte_t e);
      host.frame(7'h15, c, 8'h00, 0, 1'b1, d, ok);
      `CHK("read", e, d)
   endtask
   // Restore from storage needs time before the first frame
   task automatic do_reset();
      reset_in = 1'b1;
      repeat (6) @(negedge core_clk_in);
      reset_in = 1'b0;
      repeat (30) @(negedge core_clk_in);
   endtask
   task automatic summarize();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic t_gates();
      rd(8'h01, 8'h00);
      rd(8'h02, 8'h17);
      for (int i = 0; i < 2; i++) begin
         en_pin_in = i[0];
         settle();
         `CHK("en pin", i[0], en)
      end
      wr(8'h02, 8'hE8, 1);
      rd(8'h02, 8'hFB);
      wr(8'h01, 8'h80, 1);
      `CHK("en on", 1'b1, en)
      wr(8'h01, 8'h00, 1);
      `CHK("en off", 1'b0, en)
      wr(8'h02, 8'h0C, 1);
      for (int i = 0; i < 4; i++) begin
         wr(8'h01, {i[1], 7'h00}, 1);
         en_pin_in = i[0];
         settle();
         `CHK("en and", i[1] & i[0], en)
      end
      wr(8'h02, 8'h00, 1);
      en_pin_in = 1'b0;
      settle();
      `CHK("en auto", 1'b1, en)
      addr_done_in = 1'b0;
      host.frame(7'h15, 8'h01, 8'h00, 1, 1'b0, d, ok);
      `CHK("no ack", 1'b0, ok)
      `CHK("en wait", 1'b0, en)
      addr_done_in = 1'b1;
      settle();
   endtask
   task automatic t_margin();
      wr(8'hD5, 8'hA3, 1);
      wr(8'hD4, 8'h5A, 1);
      `CHK("trim", 8'h5A, trim)
      for (int i = 0; i < 16; i++) begin
         ex[6] = (i == 5) || (i == 6);
         ex[5] = (i == 9) || (i == 10);
         ex[4] = i[1] & (ex[6] | ex[5]);
         ex[3:0] = ex[5] ? 4'hA : (ex[6] ? 4'h3 : 4'h0);
         wr(8'h01, {2'b01, i[3:0], 2'b11}, 1);
         `CHK("margin", ex, {mlo, mhi, mact, mlvl})
      end
   endtask
   task automatic t_fault();
      wr(8'h79, 8'hFF, 1);
      `CHK("alert", 1'b0, alert)
      wr(8'h20, 8'h55, 2);
      rd(8'h01, 8'h7F);
      rd(8'h78, 8'h02);
      `CHK("alert", 1'b1, alert)
      wr(8'h03, 8'h00, 0);
      `CHK("alert", 1'b0, alert)
      wr(8'h11, 8'h00, 1);
      `CHK("alert", 1'b1, alert)
      vout_ov_in = 1'b1;
      wr(8'h03, 8'h00, 0);
      `CHK("alert", 1'b1, alert)
      rd(8'h79, 8'h3C);
      vout_ov_in = 1'b0;
      wr(8'h03, 8'h00, 0);
      `CHK("alert", 1'b0, alert)
      rd(8'h78, 8'h00);
      rd(8'h20, 8'hFF);
      `CHK("alert", 1'b1, alert)
   endtask
   task automatic t_store();
      wr(8'h02, 8'h08, 1);
      wr(8'h11, 8'h00, 0);
      wr(8'h02, 8'h04, 1);
      rd(8'h02, 8'h17);
      wr(8'h12, 8'h00, 0);
      rd(8'h02, 8'h1B);
      do_reset();
      rd(8'h02, 8'h1B);
   endtask
   // Hang guard, well above the longest expected run
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 90000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      do_reset();
      t_gates();
      t_margin();
      t_fault();
      t_store();
      summarize();
   end
endmodule // tb_pmbus_command_and_enable_control
